// [core/tbu_unpacker.sv]
// Transmit buffer unpacker: decodes command words and forwards payload bytes.
module tbu_unpacker
  import tbu_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = TBU_FIFO_DEPTH
) (
  input  wire logic        CLOCK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        WR_VALID_I,
  input  wire logic [31:0] WR_DATA_I,
  output logic             WR_READY_O,
  output logic             MAC_VALID_O,
  output logic [7:0]       MAC_BYTE_O,
  output logic             MAC_FIRST_O,
  output logic             MAC_LAST_O,
  output logic             MAC_NO_CRC_O,
  output logic             MAC_NO_PAD_O,
  output logic [15:0]      MAC_TAG_O,
  input  wire logic        MAC_READY_I,
  input  wire logic        ERR_CLR_I,
  output logic             TRANSMIT_ERROR_FLAG_O,
  input  wire logic        DONE_CLR_I,
  output logic             BUFFER_DONE_FLAG_O
);

  // Sequence state and held command words.
  tbu_state_t  state_reg, state_next;   // Current phase of the buffer.
  logic [31:0] cmd_a_reg, cmd_a_next;   // First command word of this buffer.
  logic [31:0] cmd_b_reg, cmd_b_next;   // Second command word of this packet.

  // Payload word being split into bytes.
  logic [31:0] word_reg, word_next;     // Current data word.
  logic        have_reg, have_next;     // Word still holds bytes to send.
  logic [1:0]  lane_reg, lane_next;     // Lane of the next byte to send.
  logic [10:0] left_reg, left_next;     // Payload bytes still owed by the buffer.
  logic [10:0] dw_reg, dw_next;         // Data-section words taken so far.

  // Packet bookkeeping and sticky flags.
  logic [11:0] sum_reg, sum_next;       // Running byte total of the packet.
  logic        first_reg, first_next;   // Next byte sent opens a packet.
  logic        err_reg, err_next;       // Sticky transmit error.
  logic        done_reg, done_next;     // Sticky buffer done.
  logic        err_set;                 // Error event this cycle.
  logic        done_set;                // Completion event this cycle.

  // Fields of the first command word.
  logic [1:0]  align_code;              // End alignment code.
  logic [4:0]  ofs;                     // Start offset in bytes.
  logic [10:0] size;                    // Buffer payload bytes.
  logic [10:0] skip_dw;                 // Whole words skipped before data.
  logic [11:0] end_pos;                 // Byte just past the payload.
  logic [11:0] mask;                    // Alignment rounding mask.
  logic [12:0] rounded;                 // End rounded up to the alignment.
  logic [10:0] total_dw;                // Words in the whole data section.

  // Check values computed while the second word is taken.
  logic [11:0] sum_now;                 // Packet total including this buffer.
  logic [10:0] pkt_len;                 // Length field that applies.

  // Path into the byte FIFO.
  tbu_byte_t   fifo_in;                 // Byte offered to the FIFO.
  logic        fifo_in_valid;           // Byte is offered.
  logic        fifo_in_ready;           // FIFO has room.
  tbu_byte_t   fifo_out;                // Byte at the FIFO head.

  assign align_code = cmd_a_reg[TBU_A_ALIGN_HI:TBU_A_ALIGN_LO];
  assign ofs        = cmd_a_reg[TBU_A_OFS_HI:TBU_A_OFS_LO];
  assign size       = cmd_a_reg[TBU_A_SIZE_HI:0];
  assign skip_dw    = {8'h00, ofs[4:2]};
  assign end_pos    = {7'h00, ofs} + {1'b0, size};

  always_comb begin
    case (align_code)
      TBU_ALIGN_4:  mask = TBU_MASK_4;
      TBU_ALIGN_16: mask = TBU_MASK_16;
      TBU_ALIGN_32: mask = TBU_MASK_32;
      // The reserved code is treated as plain word alignment.
      default:      mask = TBU_MASK_4;
    endcase
  end

  assign rounded  = ({1'b0, end_pos} + {1'b0, mask}) & ~{1'b0, mask};
  assign total_dw = rounded[12:2];

  assign sum_now = (cmd_a_reg[TBU_A_FIRST_BIT] ? TBU_SUM_RST : sum_reg) + {1'b0, size};
  assign pkt_len = cmd_a_reg[TBU_A_FIRST_BIT] ? WR_DATA_I[TBU_B_LEN_HI:0]
                                              : cmd_b_reg[TBU_B_LEN_HI:0];

  // Byte offered to the FIFO, built from the held word and packet controls.
  always_comb begin
    fifo_in.first  = first_reg;
    fifo_in.last   = cmd_a_reg[TBU_A_LAST_BIT] && (left_reg == 11'h001);
    fifo_in.no_crc = cmd_b_reg[TBU_B_NOCRC_BIT];
    fifo_in.no_pad = cmd_b_reg[TBU_B_NOPAD_BIT];
    fifo_in.tag    = cmd_b_reg[TBU_B_TAG_HI:TBU_B_TAG_LO];
    fifo_in.data   = word_reg[{lane_reg, 3'b000} +: 8];
  end

  // Sequencer: takes host words, strips commands, skips and filler, splits bytes.
  always_comb begin
    state_next    = state_reg;
    cmd_a_next    = cmd_a_reg;
    cmd_b_next    = cmd_b_reg;
    word_next     = word_reg;
    have_next     = have_reg;
    lane_next     = lane_reg;
    left_next     = left_reg;
    dw_next       = dw_reg;
    sum_next      = sum_reg;
    first_next    = first_reg;
    err_set       = 1'b0;
    done_set      = 1'b0;
    WR_READY_O    = 1'b0;
    fifo_in_valid = 1'b0;
    case (state_reg)
      TBU_CMD_A: begin
        WR_READY_O = 1'b1;
        if (WR_VALID_I) begin
          cmd_a_next = WR_DATA_I;
          state_next = TBU_CMD_B;
        end
      end
      // Second command word: checks happen here, before any data word.
      TBU_CMD_B: begin
        WR_READY_O = 1'b1;
        if (WR_VALID_I) begin
          if (cmd_a_reg[TBU_A_FIRST_BIT]) begin
            cmd_b_next = WR_DATA_I;
            first_next = 1'b1;
          end else if (WR_DATA_I != cmd_b_reg) begin
            err_set = 1'b1;
          end
          if (cmd_a_reg[TBU_A_LAST_BIT] && (sum_now != {1'b0, pkt_len})) begin
            err_set = 1'b1;
          end
          sum_next   = sum_now;
          left_next  = size;
          dw_next    = TBU_CNT_RST;
          have_next  = 1'b0;
          state_next = TBU_SKIP;
        end
      end
      // Whole offset words are taken and dropped.
      TBU_SKIP: begin
        if (dw_reg == skip_dw) begin
          // empty buffers go straight to the filler check
          state_next = (left_reg != TBU_CNT_RST) ? TBU_DATA : TBU_PAD;
        end else begin
          WR_READY_O = 1'b1;
          if (WR_VALID_I) begin
            dw_next = dw_reg + 11'h001;
          end
        end
      end
      // Payload words are split into bytes and pushed one per cycle.
      TBU_DATA: begin
        if (!have_reg) begin
          WR_READY_O = 1'b1;
          if (WR_VALID_I) begin
            word_next = WR_DATA_I;
            have_next = 1'b1;
            dw_next   = dw_reg + 11'h001;
            lane_next = (dw_reg == skip_dw) ? ofs[1:0] : TBU_LANE_RST;
          end
        end else begin
          fifo_in_valid = 1'b1;
          if (fifo_in_ready) begin
            first_next = 1'b0;
            left_next  = left_reg - 11'h001;
            lane_next  = lane_reg + 2'h1;
            if (left_reg == 11'h001) begin
              have_next  = 1'b0;
              state_next = TBU_PAD;
            end else if (lane_reg == 2'h3) begin
              have_next = 1'b0;
            end
          end
        end
      end
      TBU_PAD: begin
        if (dw_reg >= total_dw) begin
          done_set   = cmd_a_reg[TBU_A_DONE_BIT];
          state_next = TBU_CMD_A;
        end else begin
          WR_READY_O = 1'b1;
          if (WR_VALID_I) begin
            dw_next = dw_reg + 11'h001;
          end
        end
      end
      default: begin
        state_next = TBU_CMD_A;
      end
    endcase
    // error flag, set wins over clear
    err_next  = err_set | (err_reg & ~ERR_CLR_I);
    done_next = done_set | (done_reg & ~DONE_CLR_I);
  end

  // Registers all sequencer state.
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= TBU_CMD_A;
      cmd_a_reg <= TBU_WORD_RST;
      cmd_b_reg <= TBU_WORD_RST;
      word_reg  <= TBU_WORD_RST;
      have_reg  <= 1'b0;
      lane_reg  <= TBU_LANE_RST;
      left_reg  <= TBU_CNT_RST;
      dw_reg    <= TBU_CNT_RST;
      sum_reg   <= TBU_SUM_RST;
      first_reg <= 1'b0;
      err_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_a_reg <= cmd_a_next;
      cmd_b_reg <= cmd_b_next;
      word_reg  <= word_next;
      have_reg  <= have_next;
      lane_reg  <= lane_next;
      left_reg  <= left_next;
      dw_reg    <= dw_next;
      sum_reg   <= sum_next;
      first_reg <= first_next;
      err_reg   <= err_next;
      done_reg  <= done_next;
    end
  end

  // Byte buffer in front of the transmitter; a full buffer stalls the sequencer.
  tbu_fifo #(
    .WIDTH ($bits(tbu_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLOCK_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (fifo_in_valid),
    .in_data_i   (fifo_in),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (MAC_VALID_O),
    .out_data_o  (fifo_out),
    .out_ready_i (MAC_READY_I)
  );

  // Transmitter side fields come from the FIFO storage.
  assign MAC_BYTE_O            = fifo_out.data;
  assign MAC_FIRST_O           = fifo_out.first;
  assign MAC_LAST_O            = fifo_out.last;
  assign MAC_NO_CRC_O          = fifo_out.no_crc;
  assign MAC_NO_PAD_O          = fifo_out.no_pad;
  assign MAC_TAG_O             = fifo_out.tag;
  assign TRANSMIT_ERROR_FLAG_O = err_reg;
  assign BUFFER_DONE_FLAG_O    = done_reg;

endmodule : tbu_unpacker

// [include/tbu_pkg.sv]
// Shared constants and carrier types of the transmit buffer unpacker.
package tbu_pkg;

  // First command word: completion request, alignment, start offset, segment flags, size.
  localparam int unsigned TBU_A_DONE_BIT  = 31;
  localparam int unsigned TBU_A_ALIGN_HI  = 25;
  localparam int unsigned TBU_A_ALIGN_LO  = 24;
  localparam int unsigned TBU_A_OFS_HI    = 20;
  localparam int unsigned TBU_A_OFS_LO    = 16;
  localparam int unsigned TBU_A_FIRST_BIT = 13;
  localparam int unsigned TBU_A_LAST_BIT  = 12;
  localparam int unsigned TBU_A_SIZE_HI   = 10;

  // Second command word: tag, check-sequence disable, pad disable, packet length.
  localparam int unsigned TBU_B_TAG_HI    = 31;
  localparam int unsigned TBU_B_TAG_LO    = 16;
  localparam int unsigned TBU_B_NOCRC_BIT = 13;
  localparam int unsigned TBU_B_NOPAD_BIT = 12;
  localparam int unsigned TBU_B_LEN_HI    = 10;

  // End alignment codes and the byte masks that round a buffer end up to them.
  localparam logic [1:0]  TBU_ALIGN_4     = 2'h0;
  localparam logic [1:0]  TBU_ALIGN_16    = 2'h1;
  localparam logic [1:0]  TBU_ALIGN_32    = 2'h2;
  localparam logic [11:0] TBU_MASK_4      = 12'h003;
  localparam logic [11:0] TBU_MASK_16     = 12'h00f;
  localparam logic [11:0] TBU_MASK_32     = 12'h01f;

  // Shortest frame the transmitter pads up to unless padding is disabled.
  localparam int unsigned TBU_MIN_FRAME_BYTES = 64;

  // Depth of the byte buffer in front of the transmitter.
  localparam int unsigned TBU_FIFO_DEPTH  = 8;

  // Values after reset.
  localparam logic [31:0] TBU_WORD_RST    = 32'h0000_0000;
  localparam logic [10:0] TBU_CNT_RST     = 11'h000;
  localparam logic [11:0] TBU_SUM_RST     = 12'h000;
  localparam logic [1:0]  TBU_LANE_RST    = 2'h0;

  // Unpacker sequence states.
  typedef enum logic [2:0] {
    TBU_CMD_A,
    TBU_CMD_B,
    TBU_SKIP,
    TBU_DATA,
    TBU_PAD
  } tbu_state_t;

  // One payload byte on its way to the transmitter, with its packet controls.
  typedef struct packed {
    logic        first;
    logic        last;
    logic        no_crc;
    logic        no_pad;
    logic [15:0] tag;
    logic [7:0]  data;
  } tbu_byte_t;

endpackage : tbu_pkg

// [core/tbu_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides.
module tbu_fifo
  import tbu_pkg::*;
#(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = TBU_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage entries.
  logic [PW-1:0]    wr_reg, wr_next;  // Write index.
  logic [PW-1:0]    rd_reg, rd_next;  // Read index.
  logic [CW-1:0]    cnt_reg, cnt_next; // Number of held entries.
  logic             push;             // An entry is written this cycle.
  logic             pop;              // An entry is read this cycle.

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (cnt_reg != CW'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Index and count update, with wrap at the last entry.
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == LAST_IDX) ? '0 : wr_reg + PW'(1);
    end
    if (pop) begin
      rd_next = (rd_reg == LAST_IDX) ? '0 : rd_reg + PW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + CW'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CW'(1);
    end
  end

  // Registers the indices and the count.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Each entry loads only when the write index points at it.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        mem_reg[i] <= '0;
      end else if (push && (wr_reg == PW'(i))) begin
        mem_reg[i] <= in_data_i;
      end
    end
  end

endmodule : tbu_fifo

// [tb/tbu_unpacker_chk.sv]
// Port-level properties of the transmit buffer unpacker.
module tbu_unpacker_chk
  import tbu_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = TBU_FIFO_DEPTH
) (
  input wire logic        CLOCK_I,
  input wire logic        ARST_N_I,
  input wire logic        WR_VALID_I,
  input wire logic [31:0] WR_DATA_I,
  input wire logic        WR_READY_O,
  input wire logic        MAC_VALID_O,
  input wire logic [7:0]  MAC_BYTE_O,
  input wire logic        MAC_FIRST_O,
  input wire logic        MAC_LAST_O,
  input wire logic        MAC_NO_CRC_O,
  input wire logic        MAC_NO_PAD_O,
  input wire logic [15:0] MAC_TAG_O,
  input wire logic        MAC_READY_I,
  input wire logic        ERR_CLR_I,
  input wire logic        TRANSMIT_ERROR_FLAG_O,
  input wire logic        DONE_CLR_I,
  input wire logic        BUFFER_DONE_FLAG_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // All properties share the core clock and its reset.
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!ARST_N_I);

  AST_RESET_IDLE:
  assert property ($rose(ARST_N_I) |-> WR_READY_O && !MAC_VALID_O)
    else $error("not waiting for a command after reset");
  AST_HEAD_HOLD:
  assert property (MAC_VALID_O && !MAC_READY_I |=> MAC_VALID_O
                   && $stable({MAC_BYTE_O, MAC_FIRST_O, MAC_LAST_O, MAC_TAG_O}))
    else $error("stalled head byte changed");
  AST_SAME_PACKET:
  assert property ((MAC_VALID_O && MAC_READY_I && !MAC_LAST_O) ##1 MAC_VALID_O
                   |-> !MAC_FIRST_O && $stable(MAC_TAG_O))
    else $error("tag or first mark changed inside a packet");
  AST_ERR_STICKY:
  assert property (TRANSMIT_ERROR_FLAG_O && !ERR_CLR_I |=> TRANSMIT_ERROR_FLAG_O)
    else $error("error flag dropped without clear");
  AST_ERR_AT_B:
  assert property ($rose(TRANSMIT_ERROR_FLAG_O) |-> $past(WR_VALID_I && WR_READY_O))
    else $error("error flag rose without an accepted word");
  AST_DONE_BUBBLE:
  assert property ($rose(BUFFER_DONE_FLAG_O) |-> WR_READY_O && !$past(WR_READY_O))
    else $error("done flag not tied to buffer end");
  AST_CMD_PAIR:
  assert property ($rose(BUFFER_DONE_FLAG_O) && WR_VALID_I |=> WR_READY_O)
    else $error("second command word not accepted next");
  AST_DONE_CLR:
  assert property (DONE_CLR_I && WR_READY_O |=> !BUFFER_DONE_FLAG_O)
    else $error("done flag not cleared");

  // Main scenarios reached.
  cover property ($rose(TRANSMIT_ERROR_FLAG_O));
  cover property ($rose(BUFFER_DONE_FLAG_O));
  cover property (MAC_VALID_O && !MAC_READY_I && !WR_READY_O);
endmodule : tbu_unpacker_chk

// [tb/tbu_host_model.sv]
// Behavioural host that writes command and data words into the unpacker.
module tbu_host_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [31:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];  // Words still to be written.
  logic        gap;   // Idle cycle after an accepted word in slow mode.

  initial begin
    valid_o = 1'b0;
    data_o  = 32'h0000_0000;
  end

  // Queue one word for writing.
  task automatic put(input logic [31:0] w);
    q.push_back(w);
  endtask : put

  // words offered in order, held until accepted.
  always @(posedge clk_i) begin
    gap = slow_i && valid_o && ready_i;
    if (valid_o && ready_i) begin
      void'(q.pop_front());
    end
    if (rst_n_i && q.size() > 0 && !gap) begin
      valid_o <= 1'b1;
      data_o  <= q[0];
    end else begin
      // Released bus inverts every bit each cycle, so the old word returns on alternate cycles.
      valid_o <= 1'b0;
      data_o  <= ~data_o;
    end
  end
endmodule : tbu_host_model

// [tb/tbu_unpacker_tb.sv]
// Self-checking bench for the transmit buffer unpacker.
module tbu_unpacker_tb
  import tbu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, wr_valid, wr_ready, mac_valid, mac_first, mac_last;
  logic        mac_no_crc, mac_no_pad, err_clr, err_flag, done_clr, done_flag, slow;
  logic        mac_ready = 1'b1; // Transmitter side acceptance.
  logic [31:0] wr_data, pkt_b;   // Host word and current packet second word.
  logic [7:0]  mac_byte;
  logic [15:0] mac_tag;
  logic [1:0]  stall;            // 0 always ready, 1 intermittent, 2 stopped.
  logic [3:0]  cyc = 4'h0;
  tbu_byte_t   exp_q[$];         // Bytes the transmitter must see.
  int          bad_count, n_compared;

  tbu_unpacker #(.FIFO_DEPTH(8)) dut (.CLOCK_I(clk), .ARST_N_I(arst_n),
    .WR_VALID_I(wr_valid), .WR_DATA_I(wr_data), .WR_READY_O(wr_ready),
    .MAC_VALID_O(mac_valid), .MAC_BYTE_O(mac_byte), .MAC_FIRST_O(mac_first),
    .MAC_LAST_O(mac_last), .MAC_NO_CRC_O(mac_no_crc), .MAC_NO_PAD_O(mac_no_pad),
    .MAC_TAG_O(mac_tag), .MAC_READY_I(mac_ready), .ERR_CLR_I(err_clr),
    .TRANSMIT_ERROR_FLAG_O(err_flag), .DONE_CLR_I(done_clr), .BUFFER_DONE_FLAG_O(done_flag));
  tbu_host_model host (.clk_i(clk), .rst_n_i(arst_n), .slow_i(slow), .ready_i(wr_ready),
    .valid_o(wr_valid), .data_o(wr_data));

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Transmitter acceptance pattern.
  always @(posedge clk) begin
    cyc       <= cyc + 4'h1;
    mac_ready <= (stall == 2'h0) || (stall == 2'h1 && cyc[1:0] != 2'h0);
  end

  // Compare one value and count it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Every transmitted byte is matched against the expected stream.
  always @(posedge clk) begin
    if (arst_n && mac_valid && mac_ready) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0, "extra byte");
      else check(32'({mac_first, mac_last, mac_no_crc, mac_no_pad, mac_tag, mac_byte}),
                 32'(exp_q.pop_front()), "byte");
    end
  end

  // Verdict and end of run.
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // Queue one buffer: commands, skip words, data and filler, and its expected bytes.
  task automatic send_buf(input logic f, input logic l, input logic dn, input logic [1:0] al,
                          input logic [4:0] ofs, input logic [10:0] sz,
                          input logic [31:0] b, input logic [7:0] base);
    int          ab, nw, k;
    logic [31:0] w;
    logic [7:0]  d;
    ab = (al == TBU_ALIGN_16) ? 16 : (al == TBU_ALIGN_32) ? 32 : 4;
    nw = ((int'(ofs) + int'(sz) + ab - 1) / ab) * ab / 4;
    if (f) pkt_b = b;
    host.put({dn, 5'h00, al, 3'h0, ofs, 2'h0, f, l, 1'b0, sz});
    host.put(b);
    for (int i = 0; i < nw; i++) begin
      for (int j = 0; j < 4; j++) begin
        k = i * 4 + j - int'(ofs);
        d = (k >= 0 && k < int'(sz)) ? base + 8'(k) : 8'hc3;
        w[j*8 +: 8] = d;
        if (k >= 0 && k < int'(sz)) exp_q.push_back({f && k == 0, l && k == int'(sz) - 1,
                                                     pkt_b[13], pkt_b[12], pkt_b[31:16], d});
      end
      host.put(w);
    end
  endtask : send_buf

  // Bounded wait until every word is taken and every byte seen.
  task automatic wait_idle();
    int n;
    n = 0;
    while (n < 3000 && !(host.q.size() == 0 && exp_q.size() == 0 && wr_ready)) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) begin
      bad_count++;
      $display("unexpected at %0t: unpacker hung", $time);
      complete_run();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask : wait_idle

  // Pulse both flag clears.
  task automatic clr();
    @(posedge clk);
    err_clr  <= 1'b1;
    done_clr <= 1'b1;
    @(posedge clk);
    err_clr  <= 1'b0;
    done_clr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : clr

  // Main sequence.
  initial begin
    arst_n = 1'b0; err_clr = 1'b0; done_clr = 1'b0; slow = 1'b0; stall = 2'h0;
    bad_count = 0; n_compared = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    // Every alignment code, lanes 0..3 and skips of 0, 2, 5 and 7 words.
    for (int al = 0; al < 4; al++) begin
      send_buf(1'b1, 1'b1, 1'b1, 2'(al), 5'(al * 9 + 2), 11'(5 + al * 7),
               {16'(16'ha100 + al), 2'h0, 2'(al), 1'b0, 11'(5 + al * 7)}, 8'(al * 32));
      wait_idle();
      check(32'(err_flag), 32'h0, "length ok");
      check(32'(done_flag), 32'h1, "done set");
      clr();
      check(32'(done_flag), 32'h0, "done cleared");
    end
    $display("test alignment finished");
    // buffer count kept small.
    // Three segments, slow host and intermittent transmitter; middle one of 4 bytes.
    @(posedge clk);
    slow  <= 1'b1;
    stall <= 2'h1;
    send_buf(1'b1, 1'b0, 1'b1, 2'h1, 5'h03, 11'h003, 32'h5a5a_200c, 8'h10);
    send_buf(1'b0, 1'b0, 1'b0, 2'h0, 5'h01, 11'h004, 32'h5a5a_200c, 8'h20);
    send_buf(1'b0, 1'b1, 1'b0, 2'h2, 5'h1e, 11'h005, 32'h5a5a_200c, 8'h30);
    wait_idle();
    check(32'(err_flag), 32'h0, "sum matches");
    clr();
    $display("test segments finished");
    // Packet length one above the byte count.
    @(posedge clk);
    slow  <= 1'b0;
    stall <= 2'h0;
    send_buf(1'b1, 1'b1, 1'b0, 2'h0, 5'h00, 11'h006, 32'h0001_0007, 8'h40);
    wait_idle();
    check(32'(err_flag), 32'h1, "length mismatch");
    clr();
    check(32'(err_flag), 32'h0, "error cleared");
    // Second words differ between segments.
    send_buf(1'b1, 1'b0, 1'b0, 2'h0, 5'h00, 11'h003, 32'h00b0_0006, 8'h50);
    send_buf(1'b0, 1'b1, 1'b0, 2'h0, 5'h00, 11'h003, 32'h00b1_0006, 8'h60);
    wait_idle();
    check(32'(err_flag), 32'h1, "second words differ");
    clr();
    $display("test errors finished");
    // Stopped transmitter fills the byte buffer until the host is refused.
    @(posedge clk);
    stall <= 2'h2;
    send_buf(1'b1, 1'b1, 1'b0, 2'h0, 5'h00, 11'h028, 32'h00c0_0028, 8'h80);
    repeat (80) @(posedge clk);
    #1;
    check(32'(wr_ready), 32'h0, "refused when full");
    check(32'(mac_valid), 32'h1, "head waiting");
    @(posedge clk);
    stall <= 2'h0;
    wait_idle();
    check(32'(err_flag), 32'h0, "full buffer ok");
    $display("test backpressure finished");
    complete_run();
  end
endmodule : tbu_unpacker_tb

bind tbu_unpacker tbu_unpacker_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.CLOCK_I(CLOCK_I),
  .ARST_N_I(ARST_N_I), .WR_VALID_I(WR_VALID_I), .WR_DATA_I(WR_DATA_I),
  .WR_READY_O(WR_READY_O), .MAC_VALID_O(MAC_VALID_O), .MAC_BYTE_O(MAC_BYTE_O),
  .MAC_FIRST_O(MAC_FIRST_O), .MAC_LAST_O(MAC_LAST_O), .MAC_NO_CRC_O(MAC_NO_CRC_O),
  .MAC_NO_PAD_O(MAC_NO_PAD_O), .MAC_TAG_O(MAC_TAG_O), .MAC_READY_I(MAC_READY_I),
  .ERR_CLR_I(ERR_CLR_I), .TRANSMIT_ERROR_FLAG_O(TRANSMIT_ERROR_FLAG_O),
  .DONE_CLR_I(DONE_CLR_I), .BUFFER_DONE_FLAG_O(BUFFER_DONE_FLAG_O));
